// file: rtl/tscp_port.sv
// Purpose: Serial slave control port: two-wire, three-wire and SPI bus modes.
// Assumes: All pins are asynchronous to clock and are sampled through two flops.
// Notes:   Serial clock must stay well below a quarter of the system clock rate.
`timescale 1ns/1ps

module tscp_port #(
  parameter int CMD_FIFO_DEPTH = tscp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // Serial bus pins
  input  wire logic       sclk_i,
  input  wire logic       sdio_i,
  output logic            sdio_o,
  output logic            sdio_oe,
  input  wire logic       serial_select_n,
  // Mode and general output pins
  input  wire logic       general_out_a_i,
  output logic            general_out_a_o,
  output logic            general_out_a_oe,
  output logic            general_out_a_pullup_en,
  input  wire logic       general_out_b_i,
  output logic            general_out_b_o,
  output logic            general_out_b_oe,
  output logic            general_out_b_pulldown_en,
  output logic            general_out_c_o,
  output logic            general_out_c_oe,
  // General output configuration and interrupt sources
  input  wire logic [1:0] gpo_a_cfg,
  input  wire logic [1:0] gpo_b_cfg,
  input  wire logic [1:0] gpo_c_cfg,
  input  wire logic       general_out_b_irq,
  input  wire logic [2:0] irq_enable,
  input  wire logic       seek_tune_done_irq,
  input  wire logic       quality_irq,
  input  wire logic       rds_irq,
  // Core side
  input  wire logic       powerdown,
  output logic            core_enable,
  output logic [1:0]      bus_mode,
  output logic            cmd_valid,
  input  wire logic       cmd_ready,
  output logic [7:0]      cmd_byte,
  output logic            cmd_first,
  input  wire logic       resp_we,
  input  wire logic [3:0] resp_idx,
  input  wire logic [7:0] resp_wdata
);
  // Pin synchronisers; the first stage feeds only the second.
  logic [2:0] sclk_sy;
  logic [2:0] sdio_sy;
  logic [1:0] sen_sy;
  logic [1:0] ga_sy;
  logic [1:0] gb_sy;

  tscp_pkg::tscp_mode_e  mode_reg;
  tscp_pkg::tscp_state_e state_reg, state_next;
  logic        rst_done_reg;
  logic [7:0]  cnt_reg, cnt_next, cnt_up;
  logic [15:0] sh_reg, sh_next;
  logic [15:0] tx_reg, tx_next;
  logic        drv_reg, drv_next;
  logic        oe_reg, oe_next;
  logic        gsel_reg, gsel_next;
  logic        rd_reg, rd_next;
  logic        ack_reg, ack_next;
  logic        long_reg, long_next;
  logic [4:0]  nb_reg, nb_next;
  logic [7:0]  addr_reg, addr_next;
  logic [7:0]  cmd_buf [8];
  logic [7:0]  resp_reg [16];
  logic        byte_we, word_we, launch;
  logic [3:0]  launch_len;
  logic        push_on_reg;
  logic [3:0]  push_idx_reg, push_len_reg;
  logic        fifo_in_ready;

  wire two_wire = (mode_reg == tscp_pkg::TSCP_TWO_WIRE);
  wire spi_mode = (mode_reg == tscp_pkg::TSCP_SPI);
  wire sen_high = sen_sy[1];
  wire rise     = sclk_sy[1] & ~sclk_sy[2];
  wire fall     = ~sclk_sy[1] & sclk_sy[2];
  wire clk_high = sclk_sy[1] & sclk_sy[2];
  wire start_c  = clk_high & sdio_sy[2] & ~sdio_sy[1] & ~oe_reg;
  wire stop_c   = clk_high & ~sdio_sy[2] & sdio_sy[1] & ~oe_reg;
  wire [6:0] my_addr = sen_high ? tscp_pkg::TW_ADDR_SEL_HIGH
                                : tscp_pkg::TW_ADDR_SEL_LOW;
  wire [7:0] ctrl_bits = (mode_reg == tscp_pkg::TSCP_THREE_WIRE)
                         ? tscp_pkg::TRW_CTRL_BITS : tscp_pkg::TW_CTRL_BITS;
  wire [7:0] spi_bits  = long_reg ? tscp_pkg::SPI_LONG_BITS : tscp_pkg::BYTE_BITS;
  wire [7:0] nb_resp   = resp_reg[nb_reg[3:0]];
  wire       resp_addr = (addr_reg >= tscp_pkg::ADDR_RESP_FIRST)
                       & (addr_reg <= tscp_pkg::ADDR_RESP_LAST);
  // Response registers pair two bytes per word, lower byte index first.
  wire [15:0] rd_word  = resp_addr ? {resp_reg[{addr_reg[2:0], 1'b0}],
                                      resp_reg[{addr_reg[2:0], 1'b1}]} : 16'h0000;
  wire arg_or_cmd = (addr_reg >= tscp_pkg::ADDR_COMMAND)
                  & (addr_reg <= tscp_pkg::ADDR_ARG_LAST);
  wire spi_ga     = oe_next & gsel_next;
  wire [2:0] irq_vec = {seek_tune_done_irq, quality_irq, rds_irq};

  // Places a byte in the upper half of the transmit shifter.
  function automatic logic [15:0] byte_word(input logic [7:0] b);
    return {b, 8'h00};
  endfunction : byte_word

  // Codes 0 and 3 both leave a general output floating.
  function automatic logic gpo_drives(input logic [1:0] cfg);
    return (cfg == tscp_pkg::GPO_LOW) | (cfg == tscp_pkg::GPO_HIGH);
  endfunction : gpo_drives

  assign cnt_up  = 8'(cnt_reg + 8'h01);
  assign sh_next = rise ? {sh_reg[14:0], sdio_sy[1]} : sh_reg;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    tx_next    = tx_reg;
    drv_next   = drv_reg;
    oe_next    = oe_reg;
    gsel_next  = gsel_reg;
    rd_next    = rd_reg;
    ack_next   = ack_reg;
    long_next  = long_reg;
    nb_next    = nb_reg;
    addr_next  = addr_reg;
    byte_we    = 1'b0;
    word_we    = 1'b0;
    launch     = 1'b0;
    launch_len = two_wire ? nb_reg[3:0] : 4'h8;
    if (!rst_done_reg) begin
      state_next = tscp_pkg::TSCP_IDLE;
    end else if (two_wire && start_c) begin
      state_next = tscp_pkg::TSCP_CTRL;
      cnt_next   = 8'h00;
      nb_next    = 5'h00;
      rd_next    = 1'b0;
    end else if (two_wire && stop_c) begin
      state_next = tscp_pkg::TSCP_IDLE;
      launch     = ~rd_reg & (nb_reg != 5'h00);
    end else if (!two_wire && sen_high) begin
      // Any partial SPI command is left unlaunched here.
      state_next = tscp_pkg::TSCP_IDLE;
      oe_next    = 1'b0;
      gsel_next  = 1'b0;
    end else begin
      unique case (state_reg)
        tscp_pkg::TSCP_IDLE: begin
          if (!two_wire) begin
            state_next = tscp_pkg::TSCP_CTRL;
            cnt_next   = 8'h00;
            nb_next    = 5'h00;
          end
        end
        tscp_pkg::TSCP_CTRL: begin
          if (rise) begin
            cnt_next = cnt_up;
            if (cnt_up == ctrl_bits) begin
              cnt_next = 8'h00;
              if (two_wire) begin
                rd_next    = sh_next[0];
                state_next = (sh_next[7:1] == my_addr) ? tscp_pkg::TSCP_ACK
                                                       : tscp_pkg::TSCP_SKIP;
              end else if (!spi_mode) begin
                addr_next  = {sh_next[8:6], sh_next[4:0]};
                rd_next    = sh_next[5];
                state_next = (sh_next[8:6] != tscp_pkg::TRW_DEV_CODE) ? tscp_pkg::TSCP_SKIP
                           : sh_next[5] ? tscp_pkg::TSCP_RD : tscp_pkg::TSCP_WR;
              end else begin
                tx_next = byte_word(resp_reg[0]);
                nb_next = 5'h01;
                case (sh_next[7:0])
                  tscp_pkg::SPI_WRITE: state_next = tscp_pkg::TSCP_WR;
                  tscp_pkg::SPI_RD1_DATA, tscp_pkg::SPI_RD16_DATA: begin
                    state_next = tscp_pkg::TSCP_RD;
                    long_next  = sh_next[6];
                    gsel_next  = 1'b0;
                  end
                  tscp_pkg::SPI_RD1_GPO, tscp_pkg::SPI_RD16_GPO: begin
                    state_next = tscp_pkg::TSCP_RD;
                    long_next  = sh_next[6];
                    gsel_next  = 1'b1;
                  end
                  default: state_next = tscp_pkg::TSCP_SKIP;
                endcase
                nb_next = (sh_next[7:0] == tscp_pkg::SPI_WRITE) ? 5'h00 : 5'h01;
              end
            end
          end
        end
        tscp_pkg::TSCP_WR: begin
          if (rise) begin
            cnt_next = cnt_up;
            if (two_wire && cnt_up == tscp_pkg::BYTE_BITS) begin
              // Bytes past the eighth are refused with a missing acknowledge.
              cnt_next = 8'h00;
              if (nb_reg < tscp_pkg::CMD_BYTES) begin
                byte_we    = 1'b1;
                nb_next    = 5'(nb_reg + 5'h01);
                state_next = tscp_pkg::TSCP_ACK;
              end else begin
                state_next = tscp_pkg::TSCP_SKIP;
              end
            end else if (!two_wire && !spi_mode && cnt_up == tscp_pkg::TRW_DATA_BITS) begin
              word_we    = arg_or_cmd;
              launch     = (addr_reg == tscp_pkg::ADDR_COMMAND);
              state_next = tscp_pkg::TSCP_SKIP;
            end else if (spi_mode && cnt_up[2:0] == 3'h0) begin
              byte_we = 1'b1;
              nb_next = 5'(nb_reg + 5'h01);
              if (nb_reg == 5'(tscp_pkg::CMD_BYTES - 5'h01)) begin
                launch     = 1'b1;
                state_next = tscp_pkg::TSCP_SKIP;
              end
            end
          end
        end
        tscp_pkg::TSCP_ACK: begin
          if (fall) begin
            if (cnt_reg == 8'h00) begin
              oe_next  = 1'b1;
              drv_next = 1'b0;
              cnt_next = 8'h01;
            end else if (rd_reg) begin
              tx_next    = byte_word(nb_resp);
              drv_next   = nb_resp[7];
              nb_next    = 5'(nb_reg + 5'h01);
              cnt_next   = 8'h01;
              state_next = tscp_pkg::TSCP_RD;
            end else begin
              oe_next    = 1'b0;
              cnt_next   = 8'h00;
              state_next = tscp_pkg::TSCP_WR;
            end
          end
        end
        tscp_pkg::TSCP_RD: begin
          if (two_wire) begin
            if (fall && cnt_reg == tscp_pkg::BYTE_BITS) begin
              oe_next    = 1'b0;
              state_next = tscp_pkg::TSCP_RACK;
            end else if (fall) begin
              drv_next = tx_reg[14];
              tx_next  = {tx_reg[14:0], 1'b0};
              cnt_next = cnt_up;
            end
          end else if (!spi_mode) begin
            // Turnaround: the bus is first driven half a clock after the control word.
            if (fall && cnt_reg == 8'h00) begin
              oe_next  = 1'b1;
              tx_next  = rd_word;
              drv_next = rd_word[15];
              cnt_next = 8'h01;
            end else if (rise && cnt_reg != 8'h00) begin
              if (cnt_reg == tscp_pkg::TRW_DATA_BITS) begin
                oe_next    = 1'b0;
                state_next = tscp_pkg::TSCP_SKIP;
              end else begin
                drv_next = tx_reg[14];
                tx_next  = {tx_reg[14:0], 1'b0};
                cnt_next = cnt_up;
              end
            end
          end else if (fall) begin
            cnt_next = cnt_up;
            if (cnt_reg == spi_bits) begin
              oe_next    = 1'b0;
              state_next = tscp_pkg::TSCP_SKIP;
            end else if (cnt_reg == 8'h00) begin
              oe_next  = 1'b1;
              drv_next = tx_reg[15];
            end else if (cnt_reg[2:0] == 3'h0) begin
              tx_next  = byte_word(nb_resp);
              drv_next = nb_resp[7];
              nb_next  = 5'(nb_reg + 5'h01);
            end else begin
              drv_next = tx_reg[14];
              tx_next  = {tx_reg[14:0], 1'b0};
            end
          end
        end
        tscp_pkg::TSCP_RACK: begin
          if (rise) begin
            ack_next = ~sdio_sy[1];
          end else if (fall) begin
            if (ack_reg && nb_reg < tscp_pkg::RESP_BYTES) begin
              tx_next    = byte_word(nb_resp);
              drv_next   = nb_resp[7];
              oe_next    = 1'b1;
              nb_next    = 5'(nb_reg + 5'h01);
              cnt_next   = 8'h01;
              state_next = tscp_pkg::TSCP_RD;
            end else begin
              state_next = tscp_pkg::TSCP_SKIP;
            end
          end
        end
        tscp_pkg::TSCP_SKIP: begin
          oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    sclk_sy <= {sclk_sy[1:0], sclk_i};
    sdio_sy <= {sdio_sy[1:0], sdio_i};
    sen_sy  <= {sen_sy[0], serial_select_n};
    ga_sy   <= {ga_sy[0], general_out_a_i};
    gb_sy   <= {gb_sy[0], general_out_b_i};
  end

  // Strap capture happens in the first cycle after reset release.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rst_done_reg <= 1'b0;
      mode_reg     <= tscp_pkg::TSCP_TWO_WIRE;
    end else if (!rst_done_reg) begin
      rst_done_reg <= 1'b1;
      mode_reg     <= !ga_sy[1] ? tscp_pkg::TSCP_THREE_WIRE
                    : gb_sy[1] ? tscp_pkg::TSCP_SPI : tscp_pkg::TSCP_TWO_WIRE;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg <= tscp_pkg::TSCP_IDLE;
      cnt_reg   <= 8'h00;
      sh_reg    <= 16'h0000;
      tx_reg    <= 16'h0000;
      drv_reg   <= 1'b0;
      oe_reg    <= 1'b0;
      gsel_reg  <= 1'b0;
      rd_reg    <= 1'b0;
      ack_reg   <= 1'b0;
      long_reg  <= 1'b0;
      nb_reg    <= 5'h00;
      addr_reg  <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      tx_reg    <= tx_next;
      drv_reg   <= drv_next;
      oe_reg    <= oe_next;
      gsel_reg  <= gsel_next;
      rd_reg    <= rd_next;
      ack_reg   <= ack_next;
      long_reg  <= long_next;
      nb_reg    <= nb_next;
      addr_reg  <= addr_next;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      cmd_buf  <= '{default: 8'h00};
      resp_reg <= '{default: 8'h00};
    end else begin
      if (byte_we) cmd_buf[nb_reg[2:0]] <= sh_next[7:0];
      if (word_we) begin
        cmd_buf[{addr_reg[1:0], 1'b0}] <= sh_next[15:8];
        cmd_buf[{addr_reg[1:0], 1'b1}] <= sh_next[7:0];
      end
      if (resp_we) resp_reg[resp_idx] <= resp_wdata;
    end
  end

  // A finished command drains into the stream; a launch while draining is
  // dropped, since the host waits for clear-to-send before the next one.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      push_on_reg  <= 1'b0;
      push_idx_reg <= 4'h0;
      push_len_reg <= 4'h0;
    end else if (!push_on_reg) begin
      push_on_reg  <= launch;
      push_idx_reg <= 4'h0;
      push_len_reg <= launch_len;
    end else if (fifo_in_ready) begin
      push_idx_reg <= 4'(push_idx_reg + 4'h1);
      push_on_reg  <= (4'(push_idx_reg + 4'h1) != push_len_reg);
    end
  end

  tscp_fifo #(
    .WIDTH (tscp_pkg::FIFO_WIDTH),
    .DEPTH (CMD_FIFO_DEPTH)
  ) u_cmd_fifo (
    .clock     (clock),
    .rstn      (rstn),
    .in_valid  (push_on_reg),
    .in_ready  (fifo_in_ready),
    .in_data   ({push_idx_reg == 4'h0, cmd_buf[push_idx_reg[2:0]]}),
    .out_valid (cmd_valid),
    .out_ready (cmd_ready),
    .out_data  ({cmd_first, cmd_byte})
  );

  // Pin and core outputs; powerdown leaves the serial bus running.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sdio_o                    <= 1'b0;
      sdio_oe                   <= 1'b0;
      general_out_a_o           <= 1'b0;
      general_out_a_oe          <= 1'b0;
      general_out_a_pullup_en   <= 1'b1;
      general_out_b_o           <= 1'b0;
      general_out_b_oe          <= 1'b0;
      general_out_b_pulldown_en <= 1'b1;
      general_out_c_o           <= 1'b0;
      general_out_c_oe          <= 1'b0;
      core_enable               <= 1'b0;
      bus_mode                  <= 2'h0;
    end else begin
      sdio_o                    <= drv_next;
      sdio_oe                   <= oe_next & ~gsel_next;
      general_out_a_o           <= spi_ga ? drv_next : (gpo_a_cfg == tscp_pkg::GPO_HIGH);
      general_out_a_oe          <= spi_ga | gpo_drives(gpo_a_cfg);
      general_out_a_pullup_en   <= 1'b0;
      general_out_b_o           <= general_out_b_irq ? |(irq_vec & irq_enable)
                                                     : (gpo_b_cfg == tscp_pkg::GPO_HIGH);
      general_out_b_oe          <= general_out_b_irq | gpo_drives(gpo_b_cfg);
      general_out_b_pulldown_en <= 1'b0;
      general_out_c_o           <= (gpo_c_cfg == tscp_pkg::GPO_HIGH);
      general_out_c_oe          <= gpo_drives(gpo_c_cfg);
      core_enable               <= ~powerdown;
      bus_mode                  <= mode_reg;
    end
  end

endmodule : tscp_port

// file: rtl/tscp_pkg.sv
// Purpose: Shared constants and types of the tuner serial control port.
// Assumes: Register offsets are the eight-bit addresses seen on the three-wire bus.
// Notes:   Counts are in serial clock edges, not in system clock cycles.
package tscp_pkg;

  // Bus modes latched when reset is released.
  typedef enum logic [1:0] {TSCP_TWO_WIRE, TSCP_THREE_WIRE, TSCP_SPI} tscp_mode_e;

  // Transaction sequencer states.
  typedef enum logic [2:0] {
    TSCP_IDLE, TSCP_CTRL, TSCP_WR, TSCP_ACK, TSCP_RD, TSCP_RACK, TSCP_SKIP
  } tscp_state_e;

  // Two-wire device addresses, chosen by the serial select pin.
  localparam logic [6:0] TW_ADDR_SEL_LOW  = 7'h11;
  localparam logic [6:0] TW_ADDR_SEL_HIGH = 7'h63;

  // Three-wire register map.
  localparam logic [2:0] TRW_DEV_CODE     = 3'h5;
  localparam logic [7:0] ADDR_COMMAND     = 8'hA0;
  localparam logic [7:0] ADDR_ARG_FIRST   = 8'hA1;
  localparam logic [7:0] ADDR_ARG_LAST    = 8'hA3;
  localparam logic [7:0] ADDR_RESP_FIRST  = 8'hA8;
  localparam logic [7:0] ADDR_RESP_LAST   = 8'hAF;

  // SPI control bytes.
  localparam logic [7:0] SPI_WRITE        = 8'h48;
  localparam logic [7:0] SPI_RD1_DATA     = 8'h80;
  localparam logic [7:0] SPI_RD16_DATA    = 8'hC0;
  localparam logic [7:0] SPI_RD1_GPO      = 8'hA0;
  localparam logic [7:0] SPI_RD16_GPO     = 8'hE0;

  // Frame lengths in bits and bytes.
  localparam logic [7:0] TW_CTRL_BITS     = 8'h08;
  localparam logic [7:0] TRW_CTRL_BITS    = 8'h09;
  localparam logic [7:0] TRW_DATA_BITS    = 8'h10;
  localparam logic [7:0] BYTE_BITS        = 8'h08;
  localparam logic [7:0] SPI_LONG_BITS    = 8'h80;
  localparam logic [4:0] CMD_BYTES        = 5'h08;
  localparam logic [4:0] RESP_BYTES       = 5'h10;

  // General output configuration codes.
  localparam logic [1:0] GPO_HIZ          = 2'h0;
  localparam logic [1:0] GPO_LOW          = 2'h1;
  localparam logic [1:0] GPO_HIGH         = 2'h2;

  // Command stream buffer: bit 8 marks the command byte of a frame.
  localparam int         FIFO_WIDTH       = 9;
  localparam int         FIFO_DEPTH       = 16;

endpackage : tscp_pkg

// file: rtl/tscp_fifo.sv
// Purpose: Synchronous FIFO with a registered output stage.
// Assumes: One clock; push and pop may happen in the same cycle.
// Notes:   Holds DEPTH words in the array plus one in the output register.
`timescale 1ns/1ps
module tscp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rstn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    count_reg;
  logic             push;
  logic             load;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : ptr_inc

  assign in_ready = (count_reg != CW'(DEPTH));
  assign push     = in_valid & in_ready;
  // The output register refills whenever it is empty or being drained.
  assign load     = (count_reg != '0) & (~out_valid | out_ready);

  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      out_valid  <= 1'b0;
      out_data   <= '0;
    end else begin
      if (push) wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      if (load) rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      count_reg <= CW'(count_reg + CW'(push) - CW'(load));
      if (load) begin
        out_valid <= 1'b1;
        out_data  <= mem_reg[rd_ptr_reg];
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end

endmodule : tscp_fifo

// file: test/tscp_port_assertions.sv
// Purpose: Pin checks for the port.
// Assumes: One clock domain.
// Notes:   Bound from the bench.
`timescale 1ns/1ps
module tscp_port_assertions (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rstn,
  // Pins
  input wire logic       general_out_a_i,
  input wire logic       general_out_b_i,
  input wire logic       general_out_a_pullup_en,
  input wire logic       general_out_b_pulldown_en,
  input wire logic       sdio_oe,
  input wire logic       serial_select_n,
  input wire logic [1:0] gpo_c_cfg,
  input wire logic       general_out_c_o,
  input wire logic       general_out_c_oe,
  // Core side
  input wire logic       powerdown,
  input wire logic       core_enable,
  input wire logic [1:0] bus_mode,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic [7:0] cmd_byte
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  pulls_reset_a: assert property (disable iff (1'b0)
    !rstn ##1 !rstn |-> general_out_a_pullup_en && general_out_b_pulldown_en)
    else $error("pulls off in reset");
  reset_quiet_a: assert property (disable iff (1'b0)
    !rstn ##1 !rstn |-> !core_enable && !cmd_valid && !sdio_oe)
    else $error("active in reset");
  mode_latch_a: assert property ($rose(rstn) |=> ##1 bus_mode ==
    (!general_out_a_i ? 2'h1 : general_out_b_i ? 2'h2 : 2'h0))
    else $error("wrong bus mode");
  mode_hold_a: assert property (rstn [*4] |-> $stable(bus_mode))
    else $error("bus mode moved");
  gpo_cfg_a: assert property (rstn [*4] ##0 $stable(gpo_c_cfg) |->
    general_out_c_oe == (gpo_c_cfg inside {2'h1, 2'h2}) &&
    (!general_out_c_oe || general_out_c_o == (gpo_c_cfg == 2'h2)))
    else $error("output c wrong");
  powerdown_a: assert property (rstn [*4] ##0 $stable(powerdown) |->
    core_enable == !powerdown)
    else $error("core enable wrong");
  spi_release_a: assert property ((bus_mode == 2'h2 && serial_select_n) [*8] |->
    !sdio_oe)
    else $error("data driven unselected");
  cmd_hold_a: assert property (cmd_valid && !cmd_ready |=>
    cmd_valid && $stable(cmd_byte))
    else $error("command byte lost");
  cover property (cmd_valid && cmd_ready);
  cover property (sdio_oe && !serial_select_n);
  cover property (general_out_c_oe && general_out_c_o);
endmodule : tscp_port_assertions

// file: test/tscp_host_model.sv
// Purpose: SPI host on the serial pins.
// Assumes: 125 ns serial clock.
// Notes:   Clock stands low outside frames but for one pulse after each stop.
`timescale 1ns/1ps
module tscp_host_model (
  // Host pins
  output logic      sclk_i,
  output logic      serial_select_n,
  output logic      sdio_i,
  // Device drive
  input  wire logic sdio_o,
  input  wire logic sdio_oe,
  input  wire logic general_out_a_o,
  input  wire logic general_out_a_oe
);
  logic drv = 1'b1;
  logic rd  = 1'b0;
  // No pull on the line, so during a read a released line shows the inverse of the last host bit.
  assign sdio_i = sdio_oe ? sdio_o : (rd ? !drv : drv);
  initial begin
    sclk_i = 1'b0;
    serial_select_n = 1'b1;
  end
  task automatic start();
    serial_select_n = 1'b0;
    #62.5;
  endtask : start
  task automatic stop();
    serial_select_n = 1'b1;
    #62.5 sclk_i = 1'b1;
    #62.5 sclk_i = 1'b0;
    #62.5;
  endtask : stop
  task automatic xfer(input logic [7:0] tx, input logic read, input logic on_a,
                      output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      rd = read;
      drv = tx[i];
      #62.5 sclk_i = 1'b1;
      rx[i] = on_a ? (general_out_a_oe ? general_out_a_o : !general_out_a_o) : sdio_i;
      #62.5 sclk_i = 1'b0;
    end
  endtask : xfer
endmodule : tscp_host_model

// file: test/tscp_port_bench.sv
// Purpose: SPI mode bench for the port.
// Assumes: Mode pins held for SPI until the final reset.
// Notes:   Other bus modes are not run.
`timescale 1ns/1ps
module tscp_port_bench;
  logic       clock, rstn, sclk_i, sdio_i, sdio_o, sdio_oe, serial_select_n, powerdown;
  logic       general_out_a_i, general_out_a_o, general_out_a_oe, general_out_a_pullup_en;
  logic       general_out_b_i, general_out_b_o, general_out_b_oe, general_out_b_pulldown_en;
  logic       general_out_c_o, general_out_c_oe, general_out_b_irq, seek_tune_done_irq;
  logic       quality_irq, rds_irq, core_enable, cmd_valid, cmd_ready, cmd_first, resp_we;
  logic [1:0] gpo_a_cfg, gpo_b_cfg, gpo_c_cfg, bus_mode;
  logic [2:0] irq_enable;
  logic [3:0] resp_idx;
  logic [7:0] cmd_byte, resp_wdata, rx;
  logic [7:0] rd_code [4] = '{8'h80, 8'hC0, 8'hA0, 8'hE0};
  int         miscompares, compares, cycles, n;
  tscp_port dut_u (.*);
  tscp_host_model host_u (.*);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // The planned run is near 13230 cycles.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    {rstn, powerdown, cmd_ready, resp_we, resp_idx, resp_wdata, irq_enable} = '0;
    {general_out_a_i, general_out_b_i, general_out_b_irq, quality_irq} = 4'hF;
    {gpo_a_cfg, gpo_b_cfg, gpo_c_cfg, seek_tune_done_irq, rds_irq} = '0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    check(16'(bus_mode), 16'h0002);
    for (int c = 0; c < 4; c++) begin
      {gpo_a_cfg, gpo_b_cfg, gpo_c_cfg} <= {3{2'(c)}};
      {powerdown, general_out_b_irq, irq_enable} <= 5'(c * 9);
      repeat (8) @(posedge clock);
    end
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      {resp_we, resp_idx, resp_wdata} <= {1'b1, 4'(i), ~4'(i), 4'(i)};
      @(posedge clock);
    end
    resp_we <= 1'b0;
    // A quarter-nanosecond phase keeps every host pin change off the clock edges.
    #0.25;
    // Status is read first, so its ready bit is seen before any command.
    foreach (rd_code[k]) begin
      host_u.start();
      host_u.xfer(rd_code[k], 1'b0, 1'b0, rx);
      for (int i = 0; i < (rd_code[k][6] ? 16 : 1); i++) begin
        host_u.xfer(8'h55, 1'b1, rd_code[k][5], rx);
        check({8'h00, rx}, {8'h00, ~4'(i), 4'(i)});
      end
      host_u.stop();
    end
    $display("read test done");
    host_u.start();
    for (int i = 0; i < 4; i++) host_u.xfer(i == 0 ? 8'h48 : 8'hEE, 1'b0, 1'b0, rx);
    host_u.stop();
    host_u.start();
    host_u.xfer(8'h48, 1'b0, 1'b0, rx);
    for (int i = 0; i < 8; i++) host_u.xfer(8'h30 + 8'(i), 1'b0, 1'b0, rx);
    host_u.stop();
    @(posedge clock);
    cmd_ready <= 1'b1;
    repeat (40) begin
      @(posedge clock);
      if (cmd_valid === 1'b1) begin
        check({7'h00, cmd_first, cmd_byte}, {7'h00, n == 0, 8'h30 + 8'(n)});
        n++;
      end
    end
    check(16'(n), 16'h0008);
    $display("write test done");
    // A second reset with the first mode pin low must bring up three-wire mode.
    rstn            <= 1'b0;
    general_out_a_i <= 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    check(16'(bus_mode), 16'h0001);
    $display("mode test done");
    print_verdict();
  end
endmodule : tscp_port_bench
bind tscp_port tscp_port_assertions chk_u (.*);
